// ===== rtl/port_adc_defines.svh
/*
 Register addresses, field positions, reset values and timing counts for the
 port converter readout block. Assumes a 40 MHz device clock.
*/
// Function
// - Report averaged run current/voltage while powered
// - Twelve-bit result with offset correction applied
// - Window lasts exactly 8192 device clocks
// - Result bits 7..0 in register 011
// - Bits 11..8 plus status in register 100
// - Counter spans 4096 counts, twelve bits
// - Live count while running, hold when done
// - D7 reads 1 while integrator below zero
// - D6 reads 1 after overflow detected
// - Register 101 returns hardwired revision, part code
// - D5 select: 0 currents, 1 voltages
// - Enable mode 10 samples current even when unpowered
`ifndef PORT_ADC_DEFINES_SVH
`define PORT_ADC_DEFINES_SVH

`define ADC_ADDR_W          3
`define ADC_ADDR_LOW        3'h3
`define ADC_ADDR_HIGH       3'h4
`define ADC_ADDR_ID         3'h5

`define ADC_RES_W           12
`define ADC_FULL_SCALE      13'h1000
`define ADC_WIN_CYCLES      8192
`define ADC_WIN_W           13
`define ADC_WIN_LAST        13'h1fff

`define ADC_MODE_SAMPLE     2'h2

`define ADC_HI_ZERO_BIT     7
`define ADC_HI_OVF_BIT      6

// Identification values are arbitrary
`define ADC_REV_CODE        3'h1
`define ADC_PART_CODE       5'h0b

`define ADC_ZERO_RES        12'h000
`define ADC_ZERO_WIN        13'h0000
`define ADC_ZERO_BYTE       8'h00

`endif

// ===== rtl/port_adc_pkg.sv
/*
 Types for the port converter readout block.
 Assumes port_adc_defines.svh is on the include path.
*/
package port_adc_pkg;
  `include "port_adc_defines.svh"

  // Read request from the serial interface core
  typedef struct packed {
    logic                   rd_en;
    logic [`ADC_ADDR_W-1:0] addr;
  } reg_req_t;

  // Per-port control seen by the converter
  typedef struct packed {
    logic       powered;
    logic       volt_sel;
    logic [1:0] enable_mode;
  } port_ctrl_t;

  typedef enum logic [1:0] {
    IDLE,
    INTEGRATE,
    HOLD
  } conv_state_t;
endpackage

// ===== rtl/port_adc_readout.sv
/*
 Readout side of a slope converter: counts comparator pulses over an averaging
 window, corrects offset, and serves the result and ID registers to the serial
 interface core. Assumes the comparator and integrator-zero inputs are
 asynchronous to clk; request and control inputs come from clk logic.
*/
`timescale 1ns/1ps
`include "port_adc_defines.svh"

module port_adc_readout (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Port control
  input  wire port_adc_pkg::port_ctrl_t ctrl,
  input  wire logic [`ADC_RES_W-1:0]  offset_corr,
  // Analogue front end
  input  wire logic                   slope_pulse,
  input  wire logic                   integrator_cap_node,
  // Register read port and busy flag
  input  wire port_adc_pkg::reg_req_t req,
  output logic [7:0]                  rd_data,
  output logic                        conv_busy
);
  import port_adc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] pulse_sync_reg;
  logic [1:0] zero_sync_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_sync_reg <= 2'h0;
      zero_sync_reg  <= 2'h0;
    end else begin
      pulse_sync_reg <= {pulse_sync_reg[0], slope_pulse};
      zero_sync_reg  <= {zero_sync_reg[0], integrator_cap_node};
    end
  end

  wire pulse_s = pulse_sync_reg[1];
  wire below_s = zero_sync_reg[1];

  // ****************************************
  // Conversion control
  // ****************************************
  conv_state_t                state_reg;
  conv_state_t                state_next;
  logic [`ADC_WIN_W-1:0]      win_reg;
  logic [`ADC_RES_W-1:0]      count_reg;
  logic                       ovf_reg;
  logic                       sel_reg;
  logic [`ADC_RES_W-1:0]      result_reg;
  logic                       integrator_below_zero_flag;
  logic                       conversion_overflow_flag;

  wire start_ok  = ctrl.powered || (ctrl.enable_mode == `ADC_MODE_SAMPLE);
  wire sel_chg   = ctrl.volt_sel != sel_reg;
  wire win_end   = win_reg == `ADC_WIN_LAST;
  wire cnt_full  = count_reg == {`ADC_RES_W{1'b1}};

  // Subtract offset, clamping at zero
  function automatic logic [`ADC_RES_W-1:0] corr(input logic [`ADC_RES_W-1:0] v,
                                                 input logic [`ADC_RES_W-1:0] o);
    corr = (v > o) ? v - o : `ADC_ZERO_RES;
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE:      if (start_ok) state_next = INTEGRATE;
      INTEGRATE: begin
        if (!start_ok || sel_chg) state_next = IDLE;
        else if (win_end)         state_next = HOLD;
      end
      HOLD:      state_next = start_ok ? INTEGRATE : IDLE;
      default:   state_next = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) win_reg <= `ADC_ZERO_WIN;
    else if (state_reg == INTEGRATE) win_reg <= win_reg + 1'b1;
    else win_reg <= `ADC_ZERO_WIN;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= `ADC_ZERO_RES;
      ovf_reg   <= 1'b0;
    end else if (state_reg != INTEGRATE) begin
      count_reg <= `ADC_ZERO_RES;
      ovf_reg   <= (state_reg == HOLD) ? 1'b0 : ovf_reg;
    end else if (pulse_s) begin
      count_reg <= cnt_full ? count_reg : count_reg + 1'b1;
      ovf_reg   <= ovf_reg | cnt_full;
    end
  end

  // Live value while running, held after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg  <= IDLE;
      sel_reg    <= 1'b0;
      result_reg <= `ADC_ZERO_RES;
      conversion_overflow_flag <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg   <= ctrl.volt_sel;
      if (state_reg == INTEGRATE) result_reg <= corr(count_reg, offset_corr);
      if (state_reg == INTEGRATE && win_end) conversion_overflow_flag <= ovf_reg;
    end
  end

  assign integrator_below_zero_flag = below_s;
  assign conv_busy = state_reg == INTEGRATE;

  // ****************************************
  // Register read
  // ****************************************
  // Low result byte
  wire [7:0] low_byte  = result_reg[7:0];
  wire [7:0] high_byte = {integrator_below_zero_flag, conversion_overflow_flag, 2'b00,
                          result_reg[`ADC_RES_W-1:8]};
  wire [7:0] id_byte   = {`ADC_REV_CODE, `ADC_PART_CODE};
  wire [7:0] sel_byte  = (req.addr == `ADC_ADDR_LOW)  ? low_byte  :
                         (req.addr == `ADC_ADDR_HIGH) ? high_byte :
                         (req.addr == `ADC_ADDR_ID)   ? id_byte   : `ADC_ZERO_BYTE;

  always_ff @(posedge clk) begin
    if (!rst_n) rd_data <= `ADC_ZERO_BYTE;
    else if (req.rd_en) rd_data <= sel_byte;
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [`ADC_WIN_W:0] run_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != INTEGRATE) run_cnt <= '0;
    else run_cnt <= run_cnt + 1'b1;
  end

  AST_WINDOW_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == INTEGRATE && state_next == HOLD) |-> run_cnt == (`ADC_FULL_SCALE * 2) - 1)
    else $error("window length wrong");
  AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg != INTEGRATE |=> $stable(result_reg))
    else $error("result changed while held");
  AST_LIVE_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == INTEGRATE |=> result_reg == corr($past(count_reg), $past(offset_corr)))
    else $error("live result not tracking");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(req.rd_en) && $past(req.addr) == `ADC_ADDR_HIGH) |-> rd_data[5:4] == 2'b00)
    else $error("test bits not zero");
  AST_ID_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd_en && req.addr == `ADC_ADDR_ID) |=> rd_data == {`ADC_REV_CODE, `ADC_PART_CODE})
    else $error("id mismatch");
  AST_LOW_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd_en && req.addr == `ADC_ADDR_LOW) |=> rd_data == $past(result_reg[7:0]))
    else $error("low byte mismatch");
  AST_HIGH_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (req.rd_en && req.addr == `ADC_ADDR_HIGH) |=> rd_data[3:0] == $past(result_reg[11:8]))
    else $error("high nibble mismatch");
  AST_ZERO_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    integrator_cap_node ##1 integrator_cap_node ##1 integrator_cap_node
      |-> integrator_below_zero_flag)
    else $error("zero flag not set");
  AST_START: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == IDLE && ctrl.enable_mode == `ADC_MODE_SAMPLE) |=> state_reg == INTEGRATE)
    else $error("sample mode did not start");
  AST_COUNT_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == INTEGRATE && cnt_full && pulse_s) |=> ovf_reg)
    else $error("overflow missed");
  AST_SEL_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == INTEGRATE && sel_chg) |=> state_reg == IDLE)
    else $error("select change ignored");

  COV_DONE: cover property (@(posedge clk) state_reg == HOLD);
  COV_OVF:  cover property (@(posedge clk) conversion_overflow_flag);
  COV_VOLT: cover property (@(posedge clk) conv_busy && ctrl.volt_sel);
endmodule

// ===== verif/reg_reader_model.sv
/*
 Host model: issues single register reads on the request port.
 Assumes the answer is valid one cycle after the strobe edge.
*/
`timescale 1ns/1ps

module reg_reader_model
  import port_adc_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Request port
  output port_adc_pkg::reg_req_t req,
  input  wire logic [7:0]        rd_data
);
  // ********************
  // Read cycle
  // ********************
  initial req = '0;

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk) #2;
    req.rd_en = 1'b1;
    req.addr = a;
    @(posedge clk) #2;
    req.rd_en = 1'b0;
    // Released address no longer valid
    req.addr = ~a;
    d = rd_data;
  endtask
endmodule

// ===== verif/port_adc_readout_tb_top.sv
/*
 Self-checking bench for the converter readout block.
 Assumes a 40 MHz clock and the host model for reads.
*/
`timescale 1ns/1ps
`include "port_adc_defines.svh"

module port_adc_readout_tb_top;
  import port_adc_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] e;} row_t;
  logic       clk, rst_n, slope_pulse, integrator_cap_node, conv_busy;
  port_ctrl_t ctrl;
  logic [11:0] offset_corr;
  reg_req_t   req;
  logic [7:0] rd_data, d;
  int         mismatches, check_count, busy_cnt, k;
  row_t       rows[6] = '{'{3'h5, {`ADC_REV_CODE, `ADC_PART_CODE}}, '{3'h0, 8'h00},
                          '{3'h1, 8'h00}, '{3'h2, 8'h00}, '{3'h6, 8'h00}, '{3'h7, 8'h00}};

  port_adc_readout dut (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .offset_corr(offset_corr),
    .slope_pulse(slope_pulse), .integrator_cap_node(integrator_cap_node),
    .req(req), .rd_data(rd_data), .conv_busy(conv_busy));
  reg_reader_model u_host (.clk(clk), .req(req), .rd_data(rd_data));

  // ********************
  // Helpers
  // ********************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) if (conv_busy === 1'b1) busy_cnt++;

  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Full window, then stop the port in the hold cycle
  task automatic conv(input logic pw, input logic [1:0] m, input int np);
    ctrl.powered = pw;
    ctrl.enable_mode = m;
    for (k = 0; k < 20 && conv_busy !== 1'b1; k++) @(posedge clk) #2;
    busy_cnt = 0;
    slope_pulse = 1'b1;
    for (k = 1; k < 9000 && conv_busy === 1'b1; k++) begin
      @(posedge clk) #2;
      if (k == np) slope_pulse = 1'b0;
    end
    slope_pulse = 1'b0;
    ctrl = '0;
    chk("window", busy_cnt, 12'd0 + 8192 % 4096);
    chk("window_hi", busy_cnt / 4096, 12'h2);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    wrap_up;
  end

  // ********************
  // Tests
  // ********************
  initial begin
    rst_n = 1'b0;
    ctrl = '0;
    offset_corr = 12'h000;
    slope_pulse = 1'b0;
    integrator_cap_node = 1'b0;
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    chk("busy_reset", conv_busy, 12'h0);
    foreach (rows[i]) begin
      u_host.rd(rows[i].a, d);
      chk("rd_data", d, rows[i].e);
    end
    $display("test id done");
    offset_corr = 12'h005;
    integrator_cap_node = 1'b1;
    conv(1'b1, 2'h0, 100);
    u_host.rd(3'h3, d);
    chk("low", d, 12'h05f);
    u_host.rd(3'h4, d);
    chk("high", d, 12'h080);
    repeat (20) @(posedge clk);
    u_host.rd(3'h3, d);
    chk("held", d, 12'h05f);
    $display("test count done");
    offset_corr = 12'h000;
    integrator_cap_node = 1'b0;
    conv(1'b0, `ADC_MODE_SAMPLE, 9000);
    u_host.rd(3'h3, d);
    chk("low_sat", d, 12'h0ff);
    u_host.rd(3'h4, d);
    chk("high_ovf", d, 12'h04f);
    $display("test overflow done");
    ctrl.powered = 1'b1;
    repeat (60) @(posedge clk);
    #2 ctrl.volt_sel = 1'b1;
    @(posedge clk);
    #2 chk("abort", conv_busy, 12'h0);
    @(posedge clk);
    #2 chk("restart", conv_busy, 12'h1);
    ctrl = '0;
    $display("test select done");
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    u_host.rd(3'h4, d);
    chk("high_rst", d, 12'h000);
    $display("test reset done");
    wrap_up;
  end
endmodule
